// ---- pif_pkg.sv ----
// Function
// - Flags set on their event regardless of own enable or global enable.
// - Set flags stay set until software writes zero; never auto-cleared.
// - Bit 7 of request two sets on oscillator failure.
// - Bits 6 and 5 set on enabled comparator two/one output edges.
// - Bit 4 of request two sets when a data memory write finishes.
// - Bit 3 of request two sets on serial bus collision.
// - Bit 2 of request two sets when a display frame completes.
// - Capture/compare flags set on capture or compare match events.
// - Timer six flag sets on postscaled period match only.
// - Timer four flag sets on postscaled period match only.
// - Unimplemented request bits ignore writes and read zero.
// - Implemented flags are read/write and reset to zero.
// - Enables share flag bit positions; global enable is control bit 7.
// - Peripheral requests pass only while peripheral enable is set.
package pif_pkg;
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFF_INTCTL    = 8'h00;
  localparam logic [7:0]  OFF_EN1       = 8'h04;
  localparam logic [7:0]  OFF_EN2       = 8'h08;
  localparam logic [7:0]  OFF_EN3       = 8'h0c;
  localparam logic [7:0]  OFF_REQ1      = 8'h10;
  localparam logic [7:0]  OFF_REQ2      = 8'h14;
  localparam logic [7:0]  OFF_REQ3      = 8'h18;
  localparam logic [7:0]  OFF_STATUS    = 8'h1c;
  localparam logic [7:0]  OFF_MASK      = 8'h20;
  localparam logic [7:0]  OFF_CCPMODE   = 8'h24;
  localparam logic [7:0]  OFF_CMPEDGE   = 8'h28;
  localparam logic [7:0]  OFF_POSTSC    = 8'h2c;
  localparam int          GLB_EN_BIT    = 7;
  localparam int          PER_EN_BIT    = 6;
  localparam int          OSF_BIT       = 7;
  localparam int          C2_BIT        = 6;
  localparam int          C1_BIT        = 5;
  localparam int          NV_BIT        = 4;
  localparam int          BCL_BIT       = 3;
  localparam int          LCD_BIT       = 2;
  localparam int          CCP2_BIT      = 0;
  localparam int          CCP5_BIT      = 6;
  localparam int          CCP4_BIT      = 5;
  localparam int          CCP3_BIT      = 4;
  localparam int          T6_BIT        = 3;
  localparam int          T4_BIT        = 1;
  localparam logic [7:0]  REQ2_IMPL     = 8'hfd;
  localparam logic [7:0]  REQ3_IMPL     = 8'h7a;
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam logic [15:0] STAT_RESET    = 16'h0000;
  localparam logic [7:0]  POSTSC_RESET  = 8'h00;
  localparam logic [7:0]  EDGE_RESET    = 8'h05;
  localparam int          POST_W        = 4;
  localparam int          T4_POST_LSB   = 0;
  localparam int          T6_POST_LSB   = 4;
  localparam int          C1_RISE_BIT   = 0;
  localparam int          C1_FALL_BIT   = 1;
  localparam int          C2_RISE_BIT   = 2;
  localparam int          C2_FALL_BIT   = 3;
  localparam logic [1:0]  CCP_OFF       = 2'b00;
  localparam logic [1:0]  CCP_CAPTURE   = 2'b01;
  localparam logic [1:0]  CCP_COMPARE   = 2'b10;
  localparam logic [1:0]  CCP_PWM       = 2'b11;
  localparam logic [2:0]  HSIZE_WORD    = 3'b010;
  localparam logic        HRESP_OKAY    = 1'b0;
endpackage

// ---- pif_edge_sync.sv ----
`timescale 1ns/1ps
module pif_edge_sync
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic async_in,
  input  wire logic rise_en,
  input  wire logic fall_en,
  output logic      edge_pulse
);
  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic edge_nxt;

  assign edge_nxt = (sync_r & ~prev_r & rise_en) |
                    (~sync_r & prev_r & fall_en);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_r     <= 1'b0;
      sync_r     <= 1'b0;
      prev_r     <= 1'b0;
      edge_pulse <= 1'b0;
    end
    else
    begin
      meta_r     <= async_in;
      sync_r     <= meta_r;
      prev_r     <= sync_r;
      edge_pulse <= edge_nxt;
    end
  end
endmodule

// ---- pif_postscale.sv ----
`timescale 1ns/1ps
module pif_postscale
#(
  parameter int W = 4
)
(
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         match,
  input  wire logic [W-1:0] ratio,
  output logic              tick
);
  logic [W-1:0] cnt_r;
  logic         wrap;

  // Divides raw period matches by ratio plus one
  assign wrap = match & (cnt_r >= ratio);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      if (wrap)
        cnt_r <= '0;
      else if (match)
        cnt_r <= cnt_r + 1'b1;
      tick <= wrap;
    end
  end
endmodule

// ---- pif_ctrl.sv ----
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module pif_ctrl
(
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic                        hsel,
  input  wire logic [pif_pkg::ADDR_W-1:0]  haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic [31:0]                      hrdata,
  input  wire logic                        osc_failed,
  input  wire logic                        comparator_one_out,
  input  wire logic                        comparator_two_out,
  input  wire logic                        nv_write_done,
  input  wire logic                        bus_collision_evt,
  input  wire logic                        frame_done,
  input  wire logic [3:0]                  capcomp_event,
  input  wire logic                        timer_four_match,
  input  wire logic                        timer_six_match,
  output logic                             periph_irq,
  output logic                             irq
);
  logic [7:0]  intctl_r;
  logic [7:0]  en1_r;
  logic [7:0]  en2_r;
  logic [7:0]  en3_r;
  logic [7:0]  req1_r;
  logic [7:0]  req2_r;
  logic [7:0]  req3_r;
  logic [15:0] stat_r;
  logic [15:0] mask_r;
  logic [7:0]  ccpmode_r;
  logic [7:0]  cmpedge_r;
  logic [7:0]  postsc_r;
  logic        wr_pend_r;
  logic        rd_pend_r;
  logic [7:0]  wr_addr_r;
  logic [7:0]  rd_addr_r;
  logic        hreadyout_r;
  logic [31:0] hrdata_r;
  logic        periph_irq_r;
  logic        irq_r;

  logic [7:0]  req2_nxt;
  logic [7:0]  req3_nxt;
  logic [15:0] stat_nxt;
  logic [7:0]  ev2;
  logic [7:0]  ev3;
  logic [3:0]  ccp_ok;
  logic        osc_edge;
  logic        c1_edge;
  logic        c2_edge;
  logic        t4_tick;
  logic        t6_tick;
  logic        addr_ok;
  logic [7:0]  wdata;
  logic        wr_intctl;
  logic        wr_en1;
  logic        wr_en2;
  logic        wr_en3;
  logic        wr_req1;
  logic        wr_req2;
  logic        wr_req3;
  logic        wr_stat;
  logic        wr_mask;
  logic        wr_ccpmode;
  logic        wr_cmpedge;
  logic        wr_postsc;
  logic [31:0] rd_mux;
  logic        any_req;
  logic        glb_en;
  logic        per_en;

  // Oscillator failure and comparator outputs arrive asynchronously
  pif_edge_sync u_osc_sync
  (
    .clk        (clk),
    .reset      (reset),
    .async_in   (osc_failed),
    .rise_en    (1'b1),
    .fall_en    (1'b0),
    .edge_pulse (osc_edge)
  );

  pif_edge_sync u_c1_sync
  (
    .clk        (clk),
    .reset      (reset),
    .async_in   (comparator_one_out),
    .rise_en    (cmpedge_r[pif_pkg::C1_RISE_BIT]),
    .fall_en    (cmpedge_r[pif_pkg::C1_FALL_BIT]),
    .edge_pulse (c1_edge)
  );

  pif_edge_sync u_c2_sync
  (
    .clk        (clk),
    .reset      (reset),
    .async_in   (comparator_two_out),
    .rise_en    (cmpedge_r[pif_pkg::C2_RISE_BIT]),
    .fall_en    (cmpedge_r[pif_pkg::C2_FALL_BIT]),
    .edge_pulse (c2_edge)
  );

  pif_postscale #(.W(pif_pkg::POST_W)) u_t4_post
  (
    .clk   (clk),
    .reset (reset),
    .match (timer_four_match),
    .ratio (postsc_r[pif_pkg::T4_POST_LSB +: pif_pkg::POST_W]),
    .tick  (t4_tick)
  );

  pif_postscale #(.W(pif_pkg::POST_W)) u_t6_post
  (
    .clk   (clk),
    .reset (reset),
    .match (timer_six_match),
    .ratio (postsc_r[pif_pkg::T6_POST_LSB +: pif_pkg::POST_W]),
    .tick  (t6_tick)
  );

  // Capture/compare units 2..5 only flag in capture or compare mode
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1)
    begin : g_ccp
      assign ccp_ok[k] = capcomp_event[k] &&
        (ccpmode_r[2*k +: 2] == pif_pkg::CCP_CAPTURE ||
         ccpmode_r[2*k +: 2] == pif_pkg::CCP_COMPARE);
    end
  endgenerate

  assign ev2[pif_pkg::OSF_BIT]  = osc_edge;
  assign ev2[pif_pkg::C2_BIT]   = c2_edge;
  assign ev2[pif_pkg::C1_BIT]   = c1_edge;
  assign ev2[pif_pkg::NV_BIT]   = nv_write_done;
  assign ev2[pif_pkg::BCL_BIT]  = bus_collision_evt;
  assign ev2[pif_pkg::LCD_BIT]  = frame_done;
  assign ev2[1]                 = 1'b0;
  assign ev2[pif_pkg::CCP2_BIT] = ccp_ok[0];
  assign ev3[7]                 = 1'b0;
  assign ev3[pif_pkg::CCP5_BIT] = ccp_ok[3];
  assign ev3[pif_pkg::CCP4_BIT] = ccp_ok[2];
  assign ev3[pif_pkg::CCP3_BIT] = ccp_ok[1];
  assign ev3[pif_pkg::T6_BIT]   = t6_tick;
  assign ev3[2]                 = 1'b0;
  assign ev3[pif_pkg::T4_BIT]   = t4_tick;
  assign ev3[0]                 = 1'b0;

  // Bus decode: word transfers only, writes land in the data phase
  assign addr_ok    = hsel & hready & htrans[1] &
                      (hsize == pif_pkg::HSIZE_WORD);
  assign wdata      = hwdata[7:0];
  assign wr_intctl  = wr_pend_r & (wr_addr_r == pif_pkg::OFF_INTCTL);
  assign wr_en1     = wr_pend_r & (wr_addr_r == pif_pkg::OFF_EN1);
  assign wr_en2     = wr_pend_r & (wr_addr_r == pif_pkg::OFF_EN2);
  assign wr_en3     = wr_pend_r & (wr_addr_r == pif_pkg::OFF_EN3);
  assign wr_req1    = wr_pend_r & (wr_addr_r == pif_pkg::OFF_REQ1);
  assign wr_req2    = wr_pend_r & (wr_addr_r == pif_pkg::OFF_REQ2);
  assign wr_req3    = wr_pend_r & (wr_addr_r == pif_pkg::OFF_REQ3);
  assign wr_stat    = wr_pend_r & (wr_addr_r == pif_pkg::OFF_STATUS);
  assign wr_mask    = wr_pend_r & (wr_addr_r == pif_pkg::OFF_MASK);
  assign wr_ccpmode = wr_pend_r & (wr_addr_r == pif_pkg::OFF_CCPMODE);
  assign wr_cmpedge = wr_pend_r & (wr_addr_r == pif_pkg::OFF_CMPEDGE);
  assign wr_postsc  = wr_pend_r & (wr_addr_r == pif_pkg::OFF_POSTSC);

  // Event OR'd last so a same-cycle clearing write cannot lose it
  generate
    for (k = 0; k < 8; k = k + 1)
    begin : g_flag
      assign req2_nxt[k] = pif_pkg::REQ2_IMPL[k] &
        (ev2[k] | (wr_req2 ? wdata[k] : req2_r[k]));
      assign req3_nxt[k] = pif_pkg::REQ3_IMPL[k] &
        (ev3[k] | (wr_req3 ? wdata[k] : req3_r[k]));
    end
  endgenerate

  // Sticky status, write one to clear, event wins
  assign stat_nxt = (stat_r & ~(wr_stat ? hwdata[15:0] : 16'h0000)) |
                    {ev3 & pif_pkg::REQ3_IMPL, ev2 & pif_pkg::REQ2_IMPL};

  assign glb_en  = intctl_r[pif_pkg::GLB_EN_BIT];
  assign per_en  = intctl_r[pif_pkg::PER_EN_BIT];
  assign any_req = |(req1_r & en1_r) | |(req2_r & en2_r) |
                   |(req3_r & en3_r);

  assign rd_mux =
    (rd_addr_r == pif_pkg::OFF_INTCTL)  ? {24'h000000, intctl_r}  :
    (rd_addr_r == pif_pkg::OFF_EN1)     ? {24'h000000, en1_r}     :
    (rd_addr_r == pif_pkg::OFF_EN2)     ? {24'h000000, en2_r}     :
    (rd_addr_r == pif_pkg::OFF_EN3)     ? {24'h000000, en3_r}     :
    (rd_addr_r == pif_pkg::OFF_REQ1)    ? {24'h000000, req1_r}    :
    (rd_addr_r == pif_pkg::OFF_REQ2)    ? {24'h000000, req2_r}    :
    (rd_addr_r == pif_pkg::OFF_REQ3)    ? {24'h000000, req3_r}    :
    (rd_addr_r == pif_pkg::OFF_STATUS)  ? {16'h0000, stat_r}      :
    (rd_addr_r == pif_pkg::OFF_MASK)    ? {16'h0000, mask_r}      :
    (rd_addr_r == pif_pkg::OFF_CCPMODE) ? {24'h000000, ccpmode_r} :
    (rd_addr_r == pif_pkg::OFF_CMPEDGE) ? {24'h000000, cmpedge_r} :
    (rd_addr_r == pif_pkg::OFF_POSTSC)  ? {24'h000000, postsc_r}  :
    32'h00000000;

  // Reads take one wait state so a write just before is visible
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_pend_r   <= 1'b0;
      rd_pend_r   <= 1'b0;
      wr_addr_r   <= 8'h00;
      rd_addr_r   <= 8'h00;
      hreadyout_r <= 1'b1;
      hrdata_r    <= 32'h00000000;
    end
    else
    begin
      wr_pend_r   <= addr_ok & hwrite;
      rd_pend_r   <= addr_ok & ~hwrite;
      hreadyout_r <= ~(addr_ok & ~hwrite);
      if (addr_ok & hwrite)
        wr_addr_r <= haddr;
      if (addr_ok & ~hwrite)
        rd_addr_r <= haddr;
      if (rd_pend_r)
        hrdata_r <= rd_mux;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      intctl_r  <= pif_pkg::REG_RESET;
      en1_r     <= pif_pkg::REG_RESET;
      en2_r     <= pif_pkg::REG_RESET;
      en3_r     <= pif_pkg::REG_RESET;
      req1_r    <= pif_pkg::REG_RESET;
      ccpmode_r <= pif_pkg::REG_RESET;
      cmpedge_r <= pif_pkg::EDGE_RESET;
      postsc_r  <= pif_pkg::POSTSC_RESET;
      mask_r    <= pif_pkg::STAT_RESET;
    end
    else
    begin
      if (wr_intctl)
        intctl_r <= wdata;
      if (wr_en1)
        en1_r <= wdata;
      if (wr_en2)
        en2_r <= wdata & pif_pkg::REQ2_IMPL;
      if (wr_en3)
        en3_r <= wdata & pif_pkg::REQ3_IMPL;
      if (wr_req1)
        req1_r <= wdata;
      if (wr_ccpmode)
        ccpmode_r <= wdata;
      if (wr_cmpedge)
        cmpedge_r <= wdata;
      if (wr_postsc)
        postsc_r <= wdata;
      if (wr_mask)
        mask_r <= hwdata[15:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      req2_r       <= pif_pkg::REG_RESET;
      req3_r       <= pif_pkg::REG_RESET;
      stat_r       <= pif_pkg::STAT_RESET;
      periph_irq_r <= 1'b0;
      irq_r        <= 1'b0;
    end
    else
    begin
      req2_r       <= req2_nxt;
      req3_r       <= req3_nxt;
      stat_r       <= stat_nxt;
      periph_irq_r <= any_req & glb_en & per_en;
      irq_r        <= |(stat_r & mask_r);
    end
  end

  assign hreadyout  = hreadyout_r;
  assign hresp      = pif_pkg::HRESP_OKAY;
  assign hrdata     = hrdata_r;
  assign periph_irq = periph_irq_r;
  assign irq        = irq_r;

  chk_flag_sticky: assert property (@(posedge clk) disable iff (reset)
    !wr_req2 && !wr_req3 |=>
      (($past(req2_r) & ~req2_r) == 8'h00) &&
      (($past(req3_r) & ~req3_r) == 8'h00))
    else $error("flag cleared without a software write");

  chk_unimpl_zero: assert property (@(posedge clk) disable iff (reset)
    ##1 ((req2_r & ~pif_pkg::REQ2_IMPL) == 8'h00) &&
        ((req3_r & ~pif_pkg::REQ3_IMPL) == 8'h00))
    else $error("unimplemented request bit reads one");

  chk_event_sets: assert property (@(posedge clk) disable iff (reset)
    (ev2 != 8'h00) |=> ((req2_r & $past(ev2)) == $past(ev2)))
    else $error("event did not set its flag");

  chk_set_wins: assert property (@(posedge clk) disable iff (reset)
    wr_req2 && ev2[pif_pkg::NV_BIT] |=> req2_r[pif_pkg::NV_BIT])
    else $error("clearing write beat a same-cycle event");

  chk_pwm_ignored: assert property (@(posedge clk) disable iff (reset)
    capcomp_event[0] && ccpmode_r[1:0] == pif_pkg::CCP_PWM &&
    !req2_r[pif_pkg::CCP2_BIT] && !wr_req2
      |=> !req2_r[pif_pkg::CCP2_BIT])
    else $error("pulse-width unit raised its flag");

  chk_osc_fail: assert property (@(posedge clk) disable iff (reset)
    $rose(osc_failed) ##1 !wr_req2 [*3]
      |-> ##1 req2_r[pif_pkg::OSF_BIT])
    else $error("oscillator failure flag missed");

  chk_timer_post: assert property (@(posedge clk) disable iff (reset)
    timer_four_match &&
    postsc_r[pif_pkg::T4_POST_LSB +: pif_pkg::POST_W] == '0
    ##1 !wr_req3
      |=> req3_r[pif_pkg::T4_BIT])
    else $error("timer four match with unit ratio not flagged");

  chk_periph_gate: assert property (@(posedge clk) disable iff (reset)
    !per_en || !glb_en |=> !periph_irq_r)
    else $error("request passed with enables off");

  chk_req_out: assert property (@(posedge clk) disable iff (reset)
    any_req && glb_en && per_en |=> periph_irq_r)
    else $error("enabled request did not reach output");

  chk_read_wait: assert property (@(posedge clk) disable iff (reset)
    addr_ok && !hwrite |=> !hreadyout_r ##1 hreadyout_r)
    else $error("read wait state wrong");

  chk_irq_mask: assert property (@(posedge clk) disable iff (reset)
    (stat_r & mask_r) != 16'h0000 |=> irq_r)
    else $error("unmasked status did not raise irq");
endmodule

// ---- tb_pif_ctrl.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("BAD %s exp %h got %h", nm, e, g); \
    end \
  end

module tb_pif_ctrl;
  logic                       clk;
  logic                       reset;
  logic                       hsel;
  logic [pif_pkg::ADDR_W-1:0] haddr;
  logic [1:0]                 htrans;
  logic                       hwrite;
  logic [2:0]                 hsize;
  logic [31:0]                hwdata;
  logic                       hready;
  logic                       hreadyout;
  logic                       hresp;
  logic [31:0]                hrdata;
  logic                       osc_failed;
  logic                       comparator_one_out;
  logic                       comparator_two_out;
  logic                       nv_write_done;
  logic                       bus_collision_evt;
  logic                       frame_done;
  logic [3:0]                 capcomp_event;
  logic                       timer_four_match;
  logic                       timer_six_match;
  logic                       periph_irq;
  logic                       irq;
  int                         failures;
  int                         n_tests;
  int                         cycles = 0;
  logic [31:0]                rd;
  logic [7:0]                 offs [12];
  logic [7:0]                 rw_offs [7];
  logic [7:0]                 rw_mask [7];
  logic [7:0]                 modes [5];
  logic [7:0]                 ccp2_exp [5];
  logic [7:0]                 ccp3_exp [5];
  logic [31:0]                ctl_val [4];

  assign hready = hreadyout;

  pif_ctrl u_pif_ctrl
  (
    .clk                (clk),
    .reset              (reset),
    .hsel               (hsel),
    .haddr              (haddr),
    .htrans             (htrans),
    .hwrite             (hwrite),
    .hsize              (hsize),
    .hwdata             (hwdata),
    .hready             (hready),
    .hreadyout          (hreadyout),
    .hresp              (hresp),
    .hrdata             (hrdata),
    .osc_failed         (osc_failed),
    .comparator_one_out (comparator_one_out),
    .comparator_two_out (comparator_two_out),
    .nv_write_done      (nv_write_done),
    .bus_collision_evt  (bus_collision_evt),
    .frame_done         (frame_done),
    .capcomp_event      (capcomp_event),
    .timer_four_match   (timer_four_match),
    .timer_six_match    (timer_six_match),
    .periph_irq         (periph_irq),
    .irq                (irq)
  );

  always #12.5 clk = ~clk;

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      close_out();
    end
  end

  // One single transfer; returns at the edge that completes it
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= pif_pkg::HSIZE_WORD;
    @(posedge clk);
    while (hready !== 1'b1)
      @(posedge clk);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1)
      @(posedge clk);
    rd = hrdata;
    `CHK("hresp", pif_pkg::HRESP_OKAY, hresp)
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Order: nv, collision, frame, capcomp[3:0], timer four, timer six
  task automatic ev(input logic [8:0] v);
    {nv_write_done, bus_collision_evt, frame_done, capcomp_event,
     timer_four_match, timer_six_match} <= v;
    @(posedge clk);
    {nv_write_done, bus_collision_evt, frame_done, capcomp_event,
     timer_four_match, timer_six_match} <= 9'h000;
    @(posedge clk);
  endtask

  task automatic fin(input string nm);
    $display("test %s done", nm);
  endtask

  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
    {osc_failed, comparator_one_out, comparator_two_out} = 3'b000;
    {nv_write_done, bus_collision_evt, frame_done} = 3'b000;
    {capcomp_event, timer_four_match, timer_six_match} = 6'h00;
    failures = 0;
    n_tests = 0;
    offs = '{pif_pkg::OFF_INTCTL, pif_pkg::OFF_EN1, pif_pkg::OFF_EN2,
             pif_pkg::OFF_EN3, pif_pkg::OFF_REQ1, pif_pkg::OFF_REQ2,
             pif_pkg::OFF_REQ3, pif_pkg::OFF_STATUS, pif_pkg::OFF_MASK,
             pif_pkg::OFF_CCPMODE, pif_pkg::OFF_CMPEDGE,
             pif_pkg::OFF_POSTSC};
    rw_offs = '{pif_pkg::OFF_EN1, pif_pkg::OFF_EN2, pif_pkg::OFF_EN3,
                pif_pkg::OFF_REQ1, pif_pkg::OFF_REQ2, pif_pkg::OFF_REQ3,
                pif_pkg::OFF_INTCTL};
    rw_mask = '{8'hff, 8'hfd, 8'h7a, 8'hff, 8'hfd, 8'h7a, 8'hff};
    // Mixed modes: unit 2 pulse-width, 3 compare, 4 capture, 5 off
    modes = '{8'h55, 8'haa, 8'hff, 8'h1b, 8'h00};
    ccp2_exp = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
    ccp3_exp = '{8'h70, 8'h70, 8'h00, 8'h30, 8'h00};
    ctl_val = '{32'h80, 32'h40, 32'hc0, 32'h00};
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 12; i++)
      rchk("reset value", offs[i], (offs[i] == pif_pkg::OFF_CMPEDGE) ?
           {24'h0, pif_pkg::EDGE_RESET} : 32'h0);
    fin("reset");
    for (int i = 0; i < 7; i++)
    begin
      wr(rw_offs[i], 32'hffffffff);
      rchk("readback", rw_offs[i], {24'h0, rw_mask[i]});
      wr(rw_offs[i], 32'h0);
      rchk("cleared", rw_offs[i], 32'h0);
    end
    wr(8'h30, 32'hffffffff);
    rchk("unmapped", 8'h30, 32'h0);
    fin("access");
    wr(pif_pkg::OFF_CCPMODE, 32'h55);
    osc_failed <= 1'b1;
    comparator_one_out <= 1'b1;
    comparator_two_out <= 1'b1;
    ev(9'h1ff);
    idle(6);
    rchk("req two", pif_pkg::OFF_REQ2, 32'hfd);
    rchk("req three", pif_pkg::OFF_REQ3, 32'h7a);
    rchk("status", pif_pkg::OFF_STATUS, 32'h7afd);
    `CHK("periph gated", 1'b0, periph_irq)
    idle(20);
    rchk("sticky two", pif_pkg::OFF_REQ2, 32'hfd);
    rchk("sticky three", pif_pkg::OFF_REQ3, 32'h7a);
    fin("events");
    wr(pif_pkg::OFF_MASK, 32'h10);
    idle(3);
    `CHK("irq raised", 1'b1, irq)
    wr(pif_pkg::OFF_STATUS, 32'h10);
    idle(3);
    `CHK("irq cleared", 1'b0, irq)
    wr(pif_pkg::OFF_STATUS, 32'h0);
    rchk("status w1c", pif_pkg::OFF_STATUS, 32'h7aed);
    wr(pif_pkg::OFF_MASK, 32'h800);
    idle(3);
    `CHK("irq t6", 1'b1, irq)
    wr(pif_pkg::OFF_MASK, 32'h0);
    idle(3);
    `CHK("irq masked", 1'b0, irq)
    fin("status");
    wr(pif_pkg::OFF_REQ2, 32'h0);
    ev(9'h100);
    wr(pif_pkg::OFF_EN2, 32'h1 << pif_pkg::NV_BIT);
    for (int i = 0; i < 4; i++)
    begin
      wr(pif_pkg::OFF_INTCTL, ctl_val[i]);
      idle(3);
      `CHK("periph_irq", ctl_val[i] == 32'hc0, periph_irq)
    end
    wr(pif_pkg::OFF_EN2, 32'h0);
    fin("gating");
    fork
      wr(pif_pkg::OFF_REQ2, 32'h0);
      begin
        @(posedge clk);
        nv_write_done <= 1'b1;
        @(posedge clk);
        nv_write_done <= 1'b0;
      end
    join
    rchk("event wins", pif_pkg::OFF_REQ2, 32'h1 << pif_pkg::NV_BIT);
    fin("collision");
    for (int i = 0; i < 5; i++)
    begin
      wr(pif_pkg::OFF_CCPMODE, {24'h0, modes[i]});
      wr(pif_pkg::OFF_REQ2, 32'h0);
      wr(pif_pkg::OFF_REQ3, 32'h0);
      ev(9'h03c);
      rchk("ccp two", pif_pkg::OFF_REQ2, {24'h0, ccp2_exp[i]});
      rchk("ccp rest", pif_pkg::OFF_REQ3, {24'h0, ccp3_exp[i]});
    end
    fin("capcomp");
    wr(pif_pkg::OFF_POSTSC, 32'h12);
    ev(9'h003);
    rchk("post one", pif_pkg::OFF_REQ3, 32'h0);
    ev(9'h003);
    rchk("post two", pif_pkg::OFF_REQ3, 32'h08);
    ev(9'h002);
    rchk("post three", pif_pkg::OFF_REQ3, 32'h0a);
    fin("postscale");
    wr(pif_pkg::OFF_CMPEDGE, 32'h06);
    wr(pif_pkg::OFF_REQ2, 32'h0);
    comparator_one_out <= 1'b0;
    comparator_two_out <= 1'b0;
    idle(6);
    rchk("cmp fall", pif_pkg::OFF_REQ2, 32'h20);
    comparator_one_out <= 1'b1;
    comparator_two_out <= 1'b1;
    idle(6);
    rchk("cmp rise", pif_pkg::OFF_REQ2, 32'h60);
    fin("comparator");
    reset <= 1'b1;
    idle(2);
    reset <= 1'b0;
    rchk("rst two", pif_pkg::OFF_REQ2, 32'h0);
    rchk("rst three", pif_pkg::OFF_REQ3, 32'h0);
    rchk("rst edge", pif_pkg::OFF_CMPEDGE, {24'h0, pif_pkg::EDGE_RESET});
    fin("second reset");
    close_out();
  end
endmodule
